// >>> hdl/sergrp_map.svh
// register offsets, field positions, reset values for the status register group
// assumes a 32-bit AXI4-Lite slave with one aligned word per register
`ifndef SERGRP_MAP_SVH
`define SERGRP_MAP_SVH

// =============================================================
// operation group offsets
`define SERGRP_OPER_COND   12'h000
`define SERGRP_OPER_PTR    12'h004
`define SERGRP_OPER_NTR    12'h008
`define SERGRP_OPER_EVENT  12'h00C
`define SERGRP_OPER_ENABLE 12'h010
// =============================================================
// questionable group offsets
`define SERGRP_QUES_COND   12'h020
`define SERGRP_QUES_PTR    12'h024
`define SERGRP_QUES_NTR    12'h028
`define SERGRP_QUES_EVENT  12'h02C
`define SERGRP_QUES_ENABLE 12'h030
// =============================================================
// standard event group and status byte
`define SERGRP_STD_EVENT   12'h040
`define SERGRP_STD_ENABLE  12'h044
`define SERGRP_STATUS_BYTE 12'h048
// =============================================================
// interrupt registers
`define SERGRP_IRQ_STATUS  12'h050
`define SERGRP_IRQ_ENABLE  12'h054
`define SERGRP_IRQ_CLEAR   12'h058
// =============================================================
// field positions and reset values
`define SERGRP_SB_OPER_BIT 3'd7
`define SERGRP_SB_QUES_BIT 3'd3
`define SERGRP_STD_PON_BIT 3'd7
`define SERGRP_GRP_RESET   16'h0000
`define SERGRP_STD_RESET   8'h80
`define SERGRP_IRQ_OPER    0
`define SERGRP_IRQ_QUES    1
`define SERGRP_IRQ_STD     2
`define SERGRP_RESP_OKAY   2'b00
`define SERGRP_RESP_SLVERR 2'b10

`endif

// >>> hdl/sergrp_pkg.sv
// types shared by the status register group files
// assumes nothing beyond a SystemVerilog compiler
package sergrp_pkg;
    // =============================================================
    // bus handshake states
    typedef enum logic [1:0] {
        SERGRP_IDLE,
        SERGRP_RESP
    } sergrp_bus_state_t;
endpackage

// >>> hdl/sergrp_group.sv
// one operation or questionable register group: condition, filters, event, enable
// assumes live condition inputs synchronous to clk and a one-cycle event read strobe
`timescale 1ns/1ns
module sergrp_group #(
    parameter int WIDTH = 16                       // register width
) (
    input  wire logic             clk,              // system clock
    input  wire logic             rst,              // synchronous reset, high
    input  wire logic [WIDTH-1:0] cond_in,          // live instrument state
    input  wire logic [WIDTH-1:0] ptr_q,            // positive filter
    input  wire logic [WIDTH-1:0] ntr_q,            // negative filter
    input  wire logic [WIDTH-1:0] enable_q,         // summary mask
    input  wire logic             event_rd,         // event register read strobe
    output logic      [WIDTH-1:0] cond_q,           // condition register
    output logic      [WIDTH-1:0] event_q,          // latched event register
    output logic                  summary_q,        // or of enabled events
    output logic                  edge_seen         // any event set this cycle
);
    // =============================================================
    // transition detect
    logic [WIDTH-1:0] prev_reg;                     // last cycle condition
    logic [WIDTH-1:0] rise;                         // admitted rising edges
    logic [WIDTH-1:0] fall;                         // admitted falling edges
    logic [WIDTH-1:0] hit;                          // new event bits
    logic [WIDTH-1:0] event_next;                   // next event value

    assign cond_q     = cond_in;
    assign rise       = cond_in & ~prev_reg & ptr_q;
    assign fall       = ~cond_in & prev_reg & ntr_q;
    assign hit        = rise | fall;
    // a set landing with the read survives the clear
    assign event_next = (event_rd ? {WIDTH{1'b0}} : event_q) | hit;
    assign edge_seen  = |hit;

    // prior condition tracker
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_reg <= {WIDTH{1'b0}};
        end else begin
            prev_reg <= cond_in;
        end
    end

    // event latch and summary
    always_ff @(posedge clk) begin
        if (rst) begin
            event_q   <= {WIDTH{1'b0}};
            summary_q <= 1'b0;
        end else begin
            event_q   <= event_next;
            summary_q <= |(event_next & enable_q);
        end
    end
endmodule

// >>> hdl/sergrp_top.sv
// status register group top: operation, questionable, standard event, status byte
// assumes an AXI4-Lite master, one transfer of each kind at a time
//
// How it works
// - condition bits follow live state unlatched
// - condition read changes no register
// - filtered condition transitions set event bits
// - event bits hold until read, then clear
// - enable masks events into group summary
// - enable registers read back last write
// - positive filter rising, negative filter falling
// - both filters any change; neither, nothing
// - standard group: event and enable only
// - device clear leaves status registers alone
// - operation summary drives status byte bit 7
// - questionable summary drives status byte bit 3
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "sergrp_map.svh"
module sergrp_top
    import sergrp_pkg::*;
#(
    parameter int WIDTH = 16                       // group register width
) (
    input  wire logic             CLOCK,            // 100 MHz clock
    input  wire logic             RST,              // synchronous reset, high
    input  wire logic [WIDTH-1:0] OPER_STATE,       // live operation conditions
    input  wire logic [WIDTH-1:0] QUES_STATE,       // live questionable conditions
    input  wire logic [7:0]       STD_EVENTS,       // standard event pulses
    input  wire logic             DEV_CLEAR,        // device clear request
    input  wire logic [11:0]      S_AXI_AWADDR,     // write address
    input  wire logic             S_AXI_AWVALID,    // write address valid
    output logic                  S_AXI_AWREADY,    // write address ready
    input  wire logic [31:0]      S_AXI_WDATA,      // write data
    input  wire logic [3:0]       S_AXI_WSTRB,      // write strobes
    input  wire logic             S_AXI_WVALID,     // write data valid
    output logic                  S_AXI_WREADY,     // write data ready
    output logic [1:0]            S_AXI_BRESP,      // write response
    output logic                  S_AXI_BVALID,     // write response valid
    input  wire logic             S_AXI_BREADY,     // write response ready
    input  wire logic [11:0]      S_AXI_ARADDR,     // read address
    input  wire logic             S_AXI_ARVALID,    // read address valid
    output logic                  S_AXI_ARREADY,    // read address ready
    output logic [31:0]           S_AXI_RDATA,      // read data
    output logic [1:0]            S_AXI_RRESP,      // read response
    output logic                  S_AXI_RVALID,     // read data valid
    input  wire logic             S_AXI_RREADY,     // read data ready
    output logic [7:0]            STATUS_BYTE,      // summary status byte
    output logic                  IRQ               // level interrupt
);
    // =============================================================
    // configuration registers
    logic [WIDTH-1:0] oper_ptr_reg;                 // operation positive filter
    logic [WIDTH-1:0] oper_ntr_reg;                 // operation negative filter
    logic [WIDTH-1:0] oper_en_reg;                  // operation enable
    logic [WIDTH-1:0] ques_ptr_reg;                 // questionable positive filter
    logic [WIDTH-1:0] ques_ntr_reg;                 // questionable negative filter
    logic [WIDTH-1:0] ques_en_reg;                  // questionable enable
    logic [7:0]       std_event_reg;                // standard event latch
    logic [7:0]       std_en_reg;                   // standard enable
    logic [2:0]       irq_stat_reg;                 // sticky interrupt status
    logic [2:0]       irq_en_reg;                   // interrupt enable

    // group outputs
    logic [WIDTH-1:0] oper_cond;                    // operation condition
    logic [WIDTH-1:0] oper_event;                   // operation events
    logic             oper_sum;                     // operation summary
    logic             oper_hit;                     // operation new event
    logic [WIDTH-1:0] ques_cond;                    // questionable condition
    logic [WIDTH-1:0] ques_event;                   // questionable events
    logic             ques_sum;                     // questionable summary
    logic             ques_hit;                     // questionable new event

    // =============================================================
    // bus write side
    logic [11:0] aw_reg;                            // held write address
    logic [31:0] w_reg;                             // held write data
    logic [3:0]  ws_reg;                            // held write strobes
    logic        aw_have;                           // address captured
    logic        w_have;                            // data captured
    logic        wr_fire;                           // write commits
    logic [31:0] wmask;                             // strobe to bit mask
    logic        wr_hit;                            // address mapped

    assign wr_fire = aw_have & w_have & ~S_AXI_BVALID;
    assign wmask   = {{8{ws_reg[3]}}, {8{ws_reg[2]}}, {8{ws_reg[1]}}, {8{ws_reg[0]}}};

    // merge write data under strobes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] mask,
                                          input logic [31:0] data);
        merge = (old & ~mask) | (data & mask);
    endfunction

    // address is one of the writable registers
    function automatic logic is_writable(input logic [11:0] a);
        is_writable = (a == `SERGRP_OPER_PTR) || (a == `SERGRP_OPER_NTR) ||
                      (a == `SERGRP_OPER_ENABLE) || (a == `SERGRP_QUES_PTR) ||
                      (a == `SERGRP_QUES_NTR) || (a == `SERGRP_QUES_ENABLE) ||
                      (a == `SERGRP_STD_ENABLE) || (a == `SERGRP_IRQ_ENABLE) ||
                      (a == `SERGRP_IRQ_CLEAR);
    endfunction

    assign wr_hit = is_writable(aw_reg);

    // write address and data capture, response
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
            aw_reg       <= 12'h000;
            w_reg        <= 32'h00000000;
            ws_reg       <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `SERGRP_RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_have <= 1'b1;
                aw_reg  <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_have <= 1'b1;
                w_reg  <= S_AXI_WDATA;
                ws_reg <= S_AXI_WSTRB;
            end
            if (wr_fire) begin
                aw_have      <= 1'b0;
                w_have       <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_hit ? `SERGRP_RESP_OKAY : `SERGRP_RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // ready while nothing held for that channel and no write response pending
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
        end else begin
            S_AXI_AWREADY <= ~aw_have & ~(S_AXI_AWVALID & S_AXI_AWREADY) & ~S_AXI_BVALID;
            S_AXI_WREADY  <= ~w_have & ~(S_AXI_WVALID & S_AXI_WREADY) & ~S_AXI_BVALID;
        end
    end

    // configuration writes; device clear does not touch any of these
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            oper_ptr_reg <= `SERGRP_GRP_RESET;
            oper_ntr_reg <= `SERGRP_GRP_RESET;
            oper_en_reg  <= `SERGRP_GRP_RESET;
            ques_ptr_reg <= `SERGRP_GRP_RESET;
            ques_ntr_reg <= `SERGRP_GRP_RESET;
            ques_en_reg  <= `SERGRP_GRP_RESET;
            std_en_reg   <= 8'h00;
            irq_en_reg   <= 3'h0;
        end else if (wr_fire) begin
            case (aw_reg)
                `SERGRP_OPER_PTR:    oper_ptr_reg <= WIDTH'(merge(32'(oper_ptr_reg), wmask, w_reg));
                `SERGRP_OPER_NTR:    oper_ntr_reg <= WIDTH'(merge(32'(oper_ntr_reg), wmask, w_reg));
                `SERGRP_OPER_ENABLE: oper_en_reg  <= WIDTH'(merge(32'(oper_en_reg), wmask, w_reg));
                `SERGRP_QUES_PTR:    ques_ptr_reg <= WIDTH'(merge(32'(ques_ptr_reg), wmask, w_reg));
                `SERGRP_QUES_NTR:    ques_ntr_reg <= WIDTH'(merge(32'(ques_ntr_reg), wmask, w_reg));
                `SERGRP_QUES_ENABLE: ques_en_reg  <= WIDTH'(merge(32'(ques_en_reg), wmask, w_reg));
                `SERGRP_STD_ENABLE:  std_en_reg   <= 8'(merge(32'(std_en_reg), wmask, w_reg));
                `SERGRP_IRQ_ENABLE:  irq_en_reg   <= 3'(merge(32'(irq_en_reg), wmask, w_reg));
                default: begin
                end
            endcase
        end
    end

    // =============================================================
    // bus read side
    sergrp_bus_state_t rd_state;                    // read handshake state
    logic              rd_take;                     // read address accepted
    logic              oper_ev_rd;                  // operation event read strobe
    logic              ques_ev_rd;                  // questionable event read strobe
    logic              std_ev_rd;                   // standard event read strobe
    logic [31:0]       rd_mux;                      // selected read value
    logic              rd_hit;                      // read address mapped

    assign rd_take    = S_AXI_ARVALID & S_AXI_ARREADY;
    // event reads clear on acceptance, condition reads clear nothing
    assign oper_ev_rd = rd_take & (S_AXI_ARADDR == `SERGRP_OPER_EVENT);
    assign ques_ev_rd = rd_take & (S_AXI_ARADDR == `SERGRP_QUES_EVENT);
    assign std_ev_rd  = rd_take & (S_AXI_ARADDR == `SERGRP_STD_EVENT);

    // read data selection; enables return last written value
    assign rd_hit = (S_AXI_ARADDR[11:0] == `SERGRP_OPER_COND) || (S_AXI_ARADDR == `SERGRP_OPER_EVENT)
                  || (S_AXI_ARADDR == `SERGRP_QUES_COND) || (S_AXI_ARADDR == `SERGRP_QUES_EVENT)
                  || (S_AXI_ARADDR == `SERGRP_STD_EVENT) || (S_AXI_ARADDR == `SERGRP_STATUS_BYTE)
                  || (S_AXI_ARADDR == `SERGRP_IRQ_STATUS) || is_writable(S_AXI_ARADDR);
    assign rd_mux =
        (S_AXI_ARADDR == `SERGRP_OPER_COND)    ? 32'(oper_cond)    :
        (S_AXI_ARADDR == `SERGRP_OPER_PTR)     ? 32'(oper_ptr_reg) :
        (S_AXI_ARADDR == `SERGRP_OPER_NTR)     ? 32'(oper_ntr_reg) :
        (S_AXI_ARADDR == `SERGRP_OPER_EVENT)   ? 32'(oper_event)   :
        (S_AXI_ARADDR == `SERGRP_OPER_ENABLE)  ? 32'(oper_en_reg)  :
        (S_AXI_ARADDR == `SERGRP_QUES_COND)    ? 32'(ques_cond)    :
        (S_AXI_ARADDR == `SERGRP_QUES_PTR)     ? 32'(ques_ptr_reg) :
        (S_AXI_ARADDR == `SERGRP_QUES_NTR)     ? 32'(ques_ntr_reg) :
        (S_AXI_ARADDR == `SERGRP_QUES_EVENT)   ? 32'(ques_event)   :
        (S_AXI_ARADDR == `SERGRP_QUES_ENABLE)  ? 32'(ques_en_reg)  :
        (S_AXI_ARADDR == `SERGRP_STD_EVENT)    ? 32'(std_event_reg) :
        (S_AXI_ARADDR == `SERGRP_STD_ENABLE)   ? 32'(std_en_reg)   :
        (S_AXI_ARADDR == `SERGRP_STATUS_BYTE)  ? 32'(STATUS_BYTE)  :
        (S_AXI_ARADDR == `SERGRP_IRQ_STATUS)   ? 32'(irq_stat_reg) :
        (S_AXI_ARADDR == `SERGRP_IRQ_ENABLE)   ? 32'(irq_en_reg)   :
        32'h00000000;

    // read handshake
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            rd_state      <= SERGRP_IDLE;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h00000000;
            S_AXI_RRESP   <= `SERGRP_RESP_OKAY;
        end else begin
            case (rd_state)
                SERGRP_IDLE: begin
                    S_AXI_ARREADY <= ~rd_take;
                    if (rd_take) begin
                        S_AXI_RDATA  <= rd_mux;
                        S_AXI_RRESP  <= rd_hit ? `SERGRP_RESP_OKAY : `SERGRP_RESP_SLVERR;
                        S_AXI_RVALID <= 1'b1;
                        rd_state     <= SERGRP_RESP;
                    end
                end
                SERGRP_RESP: begin
                    if (S_AXI_RREADY) begin
                        S_AXI_RVALID  <= 1'b0;
                        S_AXI_ARREADY <= 1'b1;
                        rd_state      <= SERGRP_IDLE;
                    end
                end
                default: begin
                    rd_state <= SERGRP_IDLE;
                end
            endcase
        end
    end

    // =============================================================
    // operation and questionable groups
    sergrp_group #(.WIDTH(WIDTH)) u_oper (
        .clk       (CLOCK),
        .rst       (RST),
        .cond_in   (OPER_STATE),
        .ptr_q     (oper_ptr_reg),
        .ntr_q     (oper_ntr_reg),
        .enable_q  (oper_en_reg),
        .event_rd  (oper_ev_rd),
        .cond_q    (oper_cond),
        .event_q   (oper_event),
        .summary_q (oper_sum),
        .edge_seen (oper_hit)
    );

    sergrp_group #(.WIDTH(WIDTH)) u_ques (
        .clk       (CLOCK),
        .rst       (RST),
        .cond_in   (QUES_STATE),
        .ptr_q     (ques_ptr_reg),
        .ntr_q     (ques_ntr_reg),
        .enable_q  (ques_en_reg),
        .event_rd  (ques_ev_rd),
        .cond_q    (ques_cond),
        .event_q   (ques_event),
        .summary_q (ques_sum),
        .edge_seen (ques_hit)
    );

    // =============================================================
    // standard event group: event latch and enable only
    logic std_sum;                                  // standard summary
    logic std_hit;                                  // new standard event

    assign std_hit = |STD_EVENTS;
    assign std_sum = |(std_event_reg & std_en_reg);

    // power-on bit set at reset; set wins over read clear
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            std_event_reg <= `SERGRP_STD_RESET;
        end else begin
            std_event_reg <= (std_ev_rd ? 8'h00 : std_event_reg) | STD_EVENTS;
        end
    end

    // =============================================================
    // status byte and interrupt
    logic [2:0] irq_src;                            // interrupt event sources
    logic [2:0] irq_clr;                            // write-one-to-clear bits

    assign irq_src = {std_hit, ques_hit, oper_hit};
    assign irq_clr = (wr_fire && aw_reg == `SERGRP_IRQ_CLEAR) ? (w_reg[2:0] & wmask[2:0]) : 3'h0;

    // summaries into status byte, unaffected by device clear
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            STATUS_BYTE  <= 8'h00;
            irq_stat_reg <= 3'h0;
            IRQ          <= 1'b0;
        end else begin
            STATUS_BYTE                      <= 8'h00;
            STATUS_BYTE[`SERGRP_SB_OPER_BIT] <= oper_sum;
            STATUS_BYTE[`SERGRP_SB_QUES_BIT] <= ques_sum;
            STATUS_BYTE[5]                   <= std_sum;
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_src;
            IRQ          <= |(((irq_stat_reg & ~irq_clr) | irq_src) & irq_en_reg);
        end
    end

    // device clear only affects buffers and measurements outside this block
    logic dev_clear_unused;                         // deliberately no effect
    assign dev_clear_unused = DEV_CLEAR;
endmodule

// >>> dv/sergrp_props.sv
// checker: bus answer timing, reset values and summary clearing of the group top
// assumes only the top ports, attached by the bind at the foot
`timescale 1ns/1ns
`include "sergrp_map.svh"
module sergrp_props #(
    parameter int WIDTH = 16                  // group register width
) (
    input wire logic             CLOCK,          // clock
    input wire logic             RST,            // sync reset
    input wire logic [WIDTH-1:0] OPER_STATE,     // live state
    input wire logic             S_AXI_AWVALID,  // aw valid
    input wire logic             S_AXI_AWREADY,  // aw ready
    input wire logic             S_AXI_WVALID,   // w valid
    input wire logic             S_AXI_WREADY,   // w ready
    input wire logic             S_AXI_BVALID,   // b valid
    input wire logic             S_AXI_BREADY,   // b ready
    input wire logic [11:0]      S_AXI_ARADDR,   // ar address
    input wire logic             S_AXI_ARVALID,  // ar valid
    input wire logic             S_AXI_ARREADY,  // ar ready
    input wire logic [31:0]      S_AXI_RDATA,    // r data
    input wire logic [1:0]       S_AXI_RRESP,    // r response
    input wire logic             S_AXI_RVALID,   // r valid
    input wire logic             S_AXI_RREADY,   // r ready
    input wire logic [7:0]       STATUS_BYTE,    // status byte
    input wire logic             IRQ             // interrupt
);
    // =============================================================
    // read acceptance
    wire ar_go = S_AXI_ARVALID && S_AXI_ARREADY;  // address taken
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    // =============================================================
    // assertions
    rst_out_a: assert property ($fell(RST) |-> STATUS_BYTE == 8'h00 && !IRQ)
        else $error("outputs not cleared by reset");
    cond_rd_a: assert property (ar_go && S_AXI_ARADDR == `SERGRP_OPER_COND
        |=> S_AXI_RDATA == {16'h0000, $past(OPER_STATE)}) else $error("condition read wrong");
    rd_resp_a: assert property (ar_go |=> S_AXI_RVALID)
        else $error("read answer late");
    rd_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY
        |=> S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
    wr_resp_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
        && S_AXI_WREADY |-> ##2 S_AXI_BVALID) else $error("write answer late");
    wr_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write answer dropped");
    bad_addr_a: assert property (ar_go && S_AXI_ARADDR == 12'h04C
        |=> S_AXI_RRESP == 2'b10 && S_AXI_RDATA == 32'h00000000) else $error("bad read ok");
    evt_clr_a: assert property ($stable(OPER_STATE) ##1 (ar_go && $stable(OPER_STATE)
        && S_AXI_ARADDR == `SERGRP_OPER_EVENT) ##1 $stable(OPER_STATE) [*3]
        |=> !STATUS_BYTE[7]) else $error("summary kept after event read");
endmodule

bind sergrp_top sergrp_props #(.WIDTH(WIDTH)) props_u (.CLOCK(CLOCK), .RST(RST),
    .OPER_STATE(OPER_STATE), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .STATUS_BYTE(STATUS_BYTE),
    .IRQ(IRQ));

// >>> dv/tb.sv
// bench: filter table through both groups, then clear, interrupt and reset cases
// assumes the design and checker files are compiled first
`timescale 1ns/1ns
`include "sergrp_map.svh"
module tb;
    typedef struct {logic [11:0] b; logic [15:0] p, n, s0, s1, ev, en;} sergrp_row_t;
    logic clk = 0, rst = 1, dclr = 0, irq, awv = 0, awr, wv = 0, wr_r, bv, br = 0;
    logic arv = 0, arr, rv, rr_i = 0;
    logic [15:0] oper = 0, ques = 0;
    logic [7:0] stde = 0, sb;
    logic [11:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat;
    logic [1:0] rresp, bresp;
    int n_mismatch = 0, compares = 0;
    sergrp_row_t rows [4] = '{'{12'h000, 16'h0033, 16'h003C, 16'h00AA, 16'h0055, 16'h0039, 16'h0008},
        '{12'h020, 16'h3300, 16'h3C00, 16'hAA00, 16'h5500, 16'h3900, 16'h0100},
        '{12'h000, 16'h3300, 16'h3C00, 16'hAA00, 16'h5500, 16'h3900, 16'h4000},
        '{12'h020, 16'h0033, 16'h003C, 16'h00AA, 16'h0055, 16'h0039, 16'h0040}};
    sergrp_top dut_u (.CLOCK(clk), .RST(rst), .OPER_STATE(oper), .QUES_STATE(ques),
        .STD_EVENTS(stde), .DEV_CLEAR(dclr), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wr_r), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr_i), .STATUS_BYTE(sb),
        .IRQ(irq));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
        end while ((awv && !awr) || (wv && !wr_r));
        do @(posedge clk); while (!bv);
        br <= 1'b1;                     // late ready lets the response wait a cycle
        @(posedge clk);
        br <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
        rr_i <= 1'b1;                   // late ready lets the read data wait a cycle
        @(posedge clk);
        d = rdat;
        rr_i <= 1'b0;
    endtask
    // state change with settling gaps either side
    task automatic st(input logic [11:0] b, input logic [15:0] v);
        repeat (4) @(posedge clk);
        if (b == 12'h000) oper <= v;
        else ques <= v;
        repeat (4) @(posedge clk);
    endtask
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
    initial begin
        sergrp_row_t r;
        logic [31:0] d;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            r = rows[i];
            wr(r.b + 12'h004, {16'h0000, r.p});
            wr(r.b + 12'h008, {16'h0000, r.n});
            wr(r.b + 12'h010, {16'h0000, r.en});
            st(r.b, r.s0);
            rd(r.b + 12'h00C, d);
            st(r.b, r.s1);
            chk({31'h0, sb[r.b == 12'h000 ? 7 : 3]}, {31'h0, |(r.ev & r.en)});
            rd(r.b, d);
            chk(d, {16'h0000, r.s1});
            rd(r.b + 12'h00C, d);
            chk(d, {16'h0000, r.ev});
            rd(r.b + 12'h00C, d);
            chk(d, 32'h00000000);
            rd(r.b + 12'h010, d);
            chk(d, {16'h0000, r.en});
            $display("row %0d done", i);
        end
        @(posedge clk);
        dclr <= 1'b1;
        @(posedge clk);
        dclr <= 1'b0;
        rd(`SERGRP_QUES_ENABLE, d);
        chk(d, 32'h00000040);
        rd(12'h04C, d);
        chk({30'h0, rresp}, 32'h00000002);
        wr(`SERGRP_STATUS_BYTE, 32'h00000000);
        chk({30'h0, bresp}, 32'h00000002);
        $display("clear and unmapped done");
        wr(`SERGRP_IRQ_CLEAR, 32'h00000007);
        wr(`SERGRP_IRQ_ENABLE, 32'h00000004);
        @(posedge clk);
        stde <= 8'h10;
        @(posedge clk);
        stde <= 8'h00;
        repeat (4) @(posedge clk);
        chk({31'h0, irq}, 32'h00000001);
        rd(`SERGRP_IRQ_STATUS, d);
        chk(d, 32'h00000004);
        rd(`SERGRP_STD_EVENT, d);
        chk(d, 32'h00000090);
        wr(`SERGRP_IRQ_ENABLE, 32'h00000000);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h00000000);
        wr(`SERGRP_IRQ_ENABLE, 32'h00000004);
        wr(`SERGRP_IRQ_CLEAR, 32'h00000004);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h00000000);
        $display("interrupt done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk({24'h0, sb}, 32'h00000000);
        rd(`SERGRP_STD_EVENT, d);
        chk(d, 32'h00000080);
        rd(`SERGRP_OPER_PTR, d);
        chk(d, 32'h00000000);
        $display("reset done");
        conclude();
    end
endmodule
